// ===== pkg/mms_pkg.sv
// Purpose: constants for the monitor mode serial port.
// Assumes: 250 MHz aclk, AXI4-Lite register access.
// Notes: Functional notes follow.
package mms_pkg;
    localparam int BAUD_HZ = 28800;
    localparam int CLK_HZ = 250000000;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_HZ);
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_RXD = 8'h08;
    localparam logic [7:0] ADDR_TXD = 8'h0C;
    localparam logic [7:0] ADDR_KEYL = 8'h10;
    localparam logic [7:0] ADDR_KEYH = 8'h14;
    localparam logic [7:0] OP_READ = 8'h4A;
    localparam logic [7:0] OP_WRITE = 8'h49;
    localparam logic [7:0] OP_INDEXED_READ_CMD = 8'h1A;
    localparam logic [7:0] OP_INDEXED_WRITE_CMD = 8'h19; // Arbitrary code of our own choosing.
    localparam logic [7:0] OP_STACK_POINTER_READ_CMD = 8'h0C;
    localparam logic [7:0] OP_RUN = 8'h28;
    localparam logic [7:0] PAGE_USER = 8'hFF;
    localparam logic [7:0] PAGE_MON = 8'hFE;
    localparam logic [3:0] SEC_BYTES = 4'h8;
    localparam logic [3:0] CHAR_BITS = 4'hA;
    localparam logic [3:0] BRK_BITS = 4'hC;
    localparam logic [1:0] CATCH_CYC = 2'h2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [3:0] {
        PH_USER = 4'h1,
        PH_SEC  = 4'h2,
        PH_RDY  = 4'h4,
        PH_CMD  = 4'h8
    } mms_phase_t;
endpackage

// ===== verilog/mms_top.sv
// Purpose: monitor mode entry and single-wire host link.
// Assumes: one clock; pin inputs pass two flip-flops.
// Notes: software handles command bodies via RXD/TXD.
//
// Our own choices: register access over AXI4-Lite and the address map.
module mms_top (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // Mode pins and high voltage detectors.
    input  wire logic        irq_hv_pin,
    input  wire logic        rst_hv_pin,
    input  wire logic        mode_select_pin_a,
    input  wire logic        mode_select_pin_b,
    input  wire logic        clock_divide_select_pin,
    // Serial line, wired-OR.
    input  wire logic        serial_line_pin_i,
    output logic             serial_line_pin_o,
    output logic             serial_line_pin_oe,
    // CPU side.
    input  wire logic        soft_interrupt_instr,
    input  wire logic [15:0] cpu_vec_addr,
    output logic [15:0]      vec_addr_mapped,
    input  wire logic        watchdog_disable_cfg,
    output logic             watchdog_enable,
    output logic             clock_halve,
    output logic             monitor_mode,
    output logic             flash_access_ok,
    output logic             interrupt_return_req
);
    // Whole state of the block.
    typedef struct packed {
        logic [1:0]  s_a, s_b, s_c, s_l, s_i, s_r; // Two-stage syncs, bit 0 first.
        logic [1:0]  catch_cnt;
        logic        caught;
        logic        mon;
        logic        halve;
        mms_pkg::mms_phase_t ph;
        logic [15:0] div;
        logic [63:0] key;
        logic [2:0]  sec_idx;
        logic        sec_bad;
        logic        sec_ok;
        logic        rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_sh;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic        brk_seen;
        logic        tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_n;
        logic [11:0] tx_sh;
        logic [1:0]  op_left;
        logic [7:0]  last_op;
        logic        run;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } mms_state_t;

    mms_state_t st_reg, st_next;

    // Operand bytes that follow each opcode; unknown bytes take none.
    function automatic logic [1:0] mms_operands(input logic [7:0] op);
        unique case (op)
            mms_pkg::OP_READ:   return 2'h2;
            mms_pkg::OP_WRITE:  return 2'h3;
            mms_pkg::OP_INDEXED_WRITE_CMD: return 2'h1;
            default:            return 2'h0;
        endcase
    endfunction

    // Synchronised pin levels, read only from the second stage.
    logic rx_line, hv_any;
    assign rx_line = st_reg.s_l[1];
    assign hv_any = st_reg.s_i[1] | st_reg.s_r[1];

    // Bus handshakes: write needs both channels; one of each kind in flight.
    logic wr_go, rd_go;
    assign wr_go = s_awvalid & s_wvalid & ~st_reg.bvalid;
    assign rd_go = s_arvalid & ~st_reg.rvalid;
    assign s_awready = wr_go;
    assign s_wready = wr_go;
    assign s_arready = rd_go;
    assign s_bvalid = st_reg.bvalid;
    assign s_bresp = st_reg.bresp;
    assign s_rvalid = st_reg.rvalid;
    assign s_rresp = st_reg.rresp;
    assign s_rdata = st_reg.rdata;

    // Pin and mode outputs.
    assign serial_line_pin_o = st_reg.tx_sh[0];
    assign serial_line_pin_oe = st_reg.tx_busy;
    assign monitor_mode = st_reg.mon;
    assign clock_halve = st_reg.halve;
    assign flash_access_ok = ~st_reg.mon | st_reg.sec_ok;
    assign interrupt_return_req = st_reg.run;
    // Vectors move to the alternate page only in monitor mode.
    assign vec_addr_mapped = (st_reg.mon && cpu_vec_addr[15:8] == mms_pkg::PAGE_USER && cpu_vec_addr[7:2] == 6'h3F)
        ? {mms_pkg::PAGE_MON, cpu_vec_addr[7:0]} : cpu_vec_addr;
    // Watchdog stays off while HV is present in monitor mode.
    assign watchdog_enable = ~watchdog_disable_cfg & ~(st_reg.mon & hv_any);

    // Next-state logic.
    always_comb begin
        logic rx_done, tx_load;
        logic [11:0] tx_val;
        logic [3:0] tx_len;
        st_next = st_reg;
        rx_done = 1'b0;
        tx_load = 1'b0;
        tx_val = 12'h000;
        tx_len = 4'h0;
        st_next.run = 1'b0;
        // Pin synchronisers; every other stage ignores bit 0.
        st_next.s_a = {st_reg.s_a[0], mode_select_pin_a};
        st_next.s_b = {st_reg.s_b[0], mode_select_pin_b};
        st_next.s_c = {st_reg.s_c[0], clock_divide_select_pin};
        st_next.s_l = {st_reg.s_l[0], serial_line_pin_i};
        st_next.s_i = {st_reg.s_i[0], irq_hv_pin};
        st_next.s_r = {st_reg.s_r[0], rst_hv_pin};
        // Mode is caught once the synchronisers hold settled pin levels.
        if (!st_reg.caught) begin
            if (st_reg.catch_cnt == mms_pkg::CATCH_CYC) begin
                st_next.caught = 1'b1;
                if (st_reg.s_i[1] && st_reg.s_a[1] && !st_reg.s_b[1] && rx_line) begin
                    st_next.mon = 1'b1;
                    st_next.halve = st_reg.s_c[1];
                    st_next.ph = mms_pkg::PH_SEC;
                end
            end else begin
                st_next.catch_cnt = st_reg.catch_cnt + 2'h1;
            end
        end
        // A soft interrupt also enters monitor mode, straight to commands.
        if (st_reg.caught && !st_reg.mon && soft_interrupt_instr) begin
            st_next.mon = 1'b1;
            st_next.ph = mms_pkg::PH_CMD;
        end
        // Receiver: samples mid-bit; start, eight data, stop.
        if (!st_reg.rx_busy) begin
            if (st_reg.mon && !st_reg.tx_busy && !rx_line) begin
                st_next.rx_busy = 1'b1;
                st_next.rx_cnt = {1'b0, st_reg.div[15:1]};
                st_next.rx_bit = 4'h0;
            end
        end else if (st_reg.rx_cnt != 16'h0000) begin
            st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
        end else begin
            st_next.rx_cnt = st_reg.div;
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == 4'h0 && rx_line) begin
                st_next.rx_busy = 1'b0; // Glitch, not a start bit.
            end else if (st_reg.rx_bit != 4'h0) begin
                st_next.rx_sh = {rx_line, st_reg.rx_sh[8:1]};
            end
            if (st_reg.rx_bit == 4'h9) begin
                st_next.rx_busy = 1'b0;
                rx_done = 1'b1;
            end
        end
        // Byte handling by phase.
        if (rx_done) begin
            if (!rx_line && st_next.rx_sh[7:0] == 8'h00) begin
                st_next.brk_seen = 1'b1;
                tx_load = 1'b1;
                tx_val = 12'h003;
                tx_len = mms_pkg::BRK_BITS;
            end else if (rx_line) begin
                unique case (st_reg.ph)
                    mms_pkg::PH_SEC: begin
                        if (st_next.rx_sh[7:0] != st_reg.key[{st_reg.sec_idx, 3'h0} +: 8]) begin
                            st_next.sec_bad = 1'b1;
                        end
                        st_next.sec_idx = st_reg.sec_idx + 3'h1;
                        if (st_reg.sec_idx == 3'(mms_pkg::SEC_BYTES - 4'h1)) begin
                            st_next.ph = mms_pkg::PH_RDY;
                            st_next.sec_ok = ~st_next.sec_bad;
                        end
                    end
                    mms_pkg::PH_CMD: begin
                        tx_load = 1'b1;
                        tx_val = {2'h3, st_next.rx_sh[7:0], 1'b0, 1'b1};
                        tx_len = 4'hB;
                        st_next.rx_data = st_next.rx_sh[7:0];
                        st_next.rx_valid = 1'b1;
                        if (st_reg.op_left == 2'h0) begin
                            st_next.last_op = st_next.rx_sh[7:0];
                            st_next.op_left = mms_operands(st_next.rx_sh[7:0]);
                            st_next.run = (st_next.rx_sh[7:0] == mms_pkg::OP_RUN);
                        end else begin
                            st_next.op_left = st_reg.op_left - 2'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Ready break after the security bytes.
        if (st_reg.ph == mms_pkg::PH_RDY && !st_reg.tx_busy && !st_reg.rx_busy) begin
            tx_load = 1'b1;
            tx_val = 12'h000;
            tx_len = mms_pkg::CHAR_BITS;
            st_next.ph = mms_pkg::PH_CMD;
        end
        // Transmitter shifts one bit per divider period.
        if (st_reg.tx_busy) begin
            if (st_reg.tx_cnt != 16'h0000) begin
                st_next.tx_cnt = st_reg.tx_cnt - 16'h0001;
            end else begin
                st_next.tx_cnt = st_reg.div;
                st_next.tx_sh = {1'b1, st_reg.tx_sh[11:1]};
                st_next.tx_n = st_reg.tx_n - 4'h1;
                if (st_reg.tx_n == 4'h1) begin
                    st_next.tx_busy = 1'b0;
                end
            end
        end
        // Register writes.
        st_next.bvalid = st_reg.bvalid & ~s_bready;
        if (wr_go) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = mms_pkg::RESP_OK;
            unique case (s_awaddr)
                mms_pkg::ADDR_CTRL: if (s_wstrb[1:0] == 2'h3) st_next.div = s_wdata[15:0];
                mms_pkg::ADDR_KEYL: st_next.key[31:0] = s_wdata;
                mms_pkg::ADDR_KEYH: st_next.key[63:32] = s_wdata;
                mms_pkg::ADDR_TXD: begin
                    // Results only go out once the echo of the last byte is done.
                    if (st_reg.ph == mms_pkg::PH_CMD && !st_reg.tx_busy && !tx_load
                        && st_reg.op_left == 2'h0) begin
                        tx_load = 1'b1;
                        tx_val = {2'h3, s_wdata[7:0], 1'b0, 1'b1};
                        tx_len = 4'hB;
                    end else begin
                        st_next.bresp = mms_pkg::RESP_ERR;
                    end
                end
                default: st_next.bresp = mms_pkg::RESP_ERR;
            endcase
        end
        // Register reads; reading RXD clears its flag, a new byte wins.
        st_next.rvalid = st_reg.rvalid & ~s_rready;
        if (rd_go) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = mms_pkg::RESP_OK;
            unique case (s_araddr)
                mms_pkg::ADDR_CTRL: st_next.rdata = {16'h0000, st_reg.div};
                mms_pkg::ADDR_STAT: st_next.rdata = {15'h0000, st_reg.last_op, st_reg.ph, st_reg.brk_seen,
                                                     st_reg.tx_busy, st_reg.rx_valid, st_reg.sec_ok, st_reg.mon};
                mms_pkg::ADDR_RXD: begin
                    st_next.rdata = {24'h000000, st_reg.rx_data};
                    if (!rx_done) st_next.rx_valid = 1'b0;
                end
                mms_pkg::ADDR_KEYL: st_next.rdata = st_reg.key[31:0];
                mms_pkg::ADDR_KEYH: st_next.rdata = st_reg.key[63:32];
                default: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = mms_pkg::RESP_ERR;
                end
            endcase
        end
        // Start a character: line driven for its whole length.
        if (tx_load) begin
            st_next.tx_busy = 1'b1;
            st_next.tx_sh = tx_val;
            st_next.tx_n = tx_len;
            st_next.tx_cnt = st_reg.div;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.ph <= mms_pkg::PH_USER;
            st_reg.div <= mms_pkg::BAUD_DIV_RST;
            st_reg.key <= 64'hFFFFFFFFFFFFFFFF;
            st_reg.tx_sh <= 12'hFFF;
        end else begin
            st_reg <= st_next;
        end
    end

    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic rx_done_chk;
    assign rx_done_chk = st_reg.ph == mms_pkg::PH_CMD && st_reg.rx_busy && st_reg.rx_cnt == 16'h0000
        && st_reg.rx_bit == 4'h9 && rx_line;
    sequence s_sec_last;
        st_reg.ph == mms_pkg::PH_SEC && st_next.ph == mms_pkg::PH_RDY;
    endsequence
    sequence s_rdy_sent;
        st_reg.ph == mms_pkg::PH_CMD && st_reg.tx_busy && st_reg.tx_n == mms_pkg::CHAR_BITS;
    endsequence
    a_ready_break: assert property (s_sec_last |-> ##[1:20] s_rdy_sent)
        else $error("ready break not started");
    a_mon_entry: assert property ($rose(st_reg.mon) |-> st_reg.caught || $past(st_reg.catch_cnt) == 2'h2)
        else $error("monitor entered outside entry points");
    a_sec_wait: assert property (st_reg.ph == mms_pkg::PH_SEC |-> !st_reg.tx_busy)
        else $error("line driven during security wait");
    a_vec_map: assert property (st_reg.mon && cpu_vec_addr == 16'hFFFE |-> vec_addr_mapped == 16'hFEFE)
        else $error("reset vector not remapped");
    a_vec_user: assert property (!st_reg.mon |-> vec_addr_mapped == cpu_vec_addr)
        else $error("user vector altered");
    a_wdog_off: assert property (st_reg.mon && hv_any |-> !watchdog_enable)
        else $error("watchdog enabled under high voltage");
    a_wdog_cfg: assert property (!hv_any |-> watchdog_enable == !watchdog_disable_cfg)
        else $error("watchdog ignores config");
    a_flash_deny: assert property (st_reg.mon && !st_reg.sec_ok |-> !flash_access_ok)
        else $error("flash open without security");
    a_echo_start: assert property (rx_done_chk |=> st_reg.tx_busy && st_reg.tx_sh[1] == 1'b0)
        else $error("byte not echoed");
    a_brk_high: assert property ($rose(st_reg.brk_seen) |-> st_reg.tx_busy && st_reg.tx_sh[1:0] == 2'h3)
        else $error("break not preceded by two high bits");
endmodule

// ===== test/mms_host_model.sv
// Purpose: host computer behind the level shifter on the single serial line.
// Assumes: one bit lasts BIT_CYC aclk cycles on both sides of the link.
// Notes: the host only pulls the line low; the pull-up makes every high level.
module mms_host_model #(
    parameter int BIT_CYC = 9 // Cycles per bit, the device divisor plus one.
) (
    // Clock.
    input  wire logic aclk,
    // Resolved line level and the host's own pull-down.
    input  wire logic line,
    output logic      host_low
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       busy = 1'b0; // High while the host itself is sending.
    logic [8:0] rx_q[$];     // Frames seen on the line: stop bit over the data.
    logic [8:0] frame;       // Frame being assembled.

    initial host_low = 1'b0;

    // One bit time at one level; a high is released, never driven, so both ends can share the wire.
    task automatic put_bit(input logic v);
        begin
            host_low <= !v;
            repeat (BIT_CYC) @(posedge aclk);
        end
    endtask

    // Low start, eight data bits least significant first, high stop.
    task automatic send_byte(input logic [7:0] b);
        begin
            busy = 1'b1;
            put_bit(1'b0);
            for (int i = 0; i < 8; i++) put_bit(b[i]);
            put_bit(1'b1);
            busy = 1'b0;
        end
    endtask

    // A start bit and nine more low bits, then the line is released.
    task automatic send_break();
        begin
            busy = 1'b1;
            for (int i = 0; i < 10; i++) put_bit(1'b0);
            host_low <= 1'b0;
            // Let the release settle before listening, so our own break is not taken for a start bit.
            @(posedge aclk);
            busy = 1'b0;
        end
    endtask

    // Receiver samples at mid bit; it ignores what the host sends itself.
    initial forever begin
        @(posedge aclk);
        if (line === 1'b0 && !busy) begin
            repeat (BIT_CYC / 2) @(posedge aclk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CYC) @(posedge aclk);
                frame[i] = line;
            end
            rx_q.push_back(frame);
            // A break keeps the line low past its stop sample; wait for idle first.
            while (line === 1'b0) @(posedge aclk);
        end
    end
endmodule

// ===== test/tb_top.sv
// Purpose: self-checking bench for the monitor mode serial port.
// Assumes: divisor 8 is written through CTRL, so one bit lasts nine aclk cycles.
// Notes: the line is resolved here from both pull-downs and the pull-up.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BIT = 9; // Cycles per bit with divisor 8.
    // Inputs of the design, all valued at time zero.
    logic        aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
    logic        s_bready = 1'b1, s_rready = 1'b1, irq_hv_pin = 1'b0, rst_hv_pin = 1'b0;
    logic        mode_select_pin_a = 1'b1, mode_select_pin_b = 1'b0, clock_divide_select_pin = 1'b0;
    logic        soft_interrupt_instr = 1'b0, watchdog_disable_cfg = 1'b0;
    logic [3:0]  s_wstrb = 4'hF;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [15:0] cpu_vec_addr = 16'h0000;
    logic [31:0] s_wdata = 32'h0;
    // Outputs of the design and the resolved line.
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, serial_line_pin_i;
    logic        serial_line_pin_o, serial_line_pin_oe, host_low, watchdog_enable;
    logic        clock_halve, monitor_mode, flash_access_ok, interrupt_return_req;
    logic [1:0]  s_bresp, s_rresp;
    logic [15:0] vec_addr_mapped;
    logic [31:0] s_rdata;
    int          bad_count = 0, checks = 0, cycles = 0, run_pulses = 0;

    // Wired-OR pin: low wins, the pull-up gives high when nobody pulls.
    assign serial_line_pin_i = !((serial_line_pin_oe && !serial_line_pin_o) || host_low);

    mms_top mms_top_inst (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .irq_hv_pin, .rst_hv_pin, .mode_select_pin_a, .mode_select_pin_b,
        .clock_divide_select_pin, .serial_line_pin_i, .serial_line_pin_o, .serial_line_pin_oe,
        .soft_interrupt_instr, .cpu_vec_addr, .vec_addr_mapped, .watchdog_disable_cfg,
        .watchdog_enable, .clock_halve, .monitor_mode, .flash_access_ok, .interrupt_return_req);

    mms_host_model #(.BIT_CYC(BIT)) host_inst (.aclk(aclk), .line(serial_line_pin_i), .host_low(host_low));

    initial forever #2 aclk = ~aclk;

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        begin
            $display("Comparisons %0d, mismatches %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // Counts run requests; a hang is cut short here.
    always @(posedge aclk) begin
        cycles++;
        if (interrupt_return_req === 1'b1) run_pulses++;
        if (cycles == 40000) begin
            bad_count++;
            close_out();
        end
    end

    // Write with address and data offered together, each released when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        begin
            aw_ok = 1'b0;
            w_ok = 1'b0;
            s_awaddr <= a;
            s_wdata <= d;
            s_awvalid <= 1'b1;
            s_wvalid <= 1'b1;
            while (!(aw_ok && w_ok)) begin
                @(posedge aclk);
                aw_ok = aw_ok || s_awready;
                w_ok = w_ok || s_wready;
                if (aw_ok) s_awvalid <= 1'b0;
                if (w_ok) s_wvalid <= 1'b0;
            end
            do @(posedge aclk); while (s_bvalid !== 1'b1);
            r = s_bresp;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        begin
            s_araddr <= a;
            s_arvalid <= 1'b1;
            do @(posedge aclk); while (s_arready !== 1'b1);
            s_arvalid <= 1'b0;
            do @(posedge aclk); while (s_rvalid !== 1'b1);
            d = s_rdata;
            r = s_rresp;
        end
    endtask

    // Reset with the mode pins held stable across the release.
    task automatic do_reset(input logic hv, input logic b, input logic div);
        begin
            irq_hv_pin <= hv;
            mode_select_pin_b <= b;
            clock_divide_select_pin <= div;
            aresetn <= 1'b0;
            repeat (4) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (6) @(posedge aclk);
        end
    endtask

    task automatic gap(input int n);
        repeat (n * BIT) @(posedge aclk);
    endtask

    // The four top vector addresses must land on the given page.
    task automatic vec_chk(input logic [7:0] page);
        for (int i = 0; i < 4; i++) begin
            cpu_vec_addr <= 16'hFFFC + 16'(i);
            @(negedge aclk);
            `CHK(vec_addr_mapped, {page, 8'hFC + 8'(i)})
            @(posedge aclk);
        end
    endtask

    // Sends one byte and expects exactly its echo back.
    task automatic echo_byte(input logic [7:0] b);
        begin
            host_inst.rx_q.delete();
            host_inst.send_byte(b);
            gap(14);
            `CHK(host_inst.rx_q[$], {1'b1, b})
        end
    endtask

    // User mode, a wrong pin pattern, then entry by the soft interrupt.
    task automatic t_entry();
        logic [1:0] r;
        logic [31:0] d;
        begin
            do_reset(1'b0, 1'b0, 1'b0);
            `CHK(monitor_mode, 1'b0)
            `CHK(flash_access_ok, 1'b1)
            `CHK(watchdog_enable, 1'b1)
            vec_chk(mms_pkg::PAGE_USER);
            axi_rd(8'h40, d, r);
            `CHK(r, mms_pkg::RESP_ERR)
            `CHK(d, 32'h0)
            do_reset(1'b1, 1'b1, 1'b0);
            `CHK(monitor_mode, 1'b0)
            soft_interrupt_instr <= 1'b1;
            @(posedge aclk);
            soft_interrupt_instr <= 1'b0;
            repeat (3) @(posedge aclk);
            `CHK(monitor_mode, 1'b1)
            `CHK(watchdog_enable, 1'b0)
            vec_chk(mms_pkg::PAGE_MON);
        end
    endtask

    // Entry by reset, eight security bytes, then the ready break.
    task automatic t_secure(input logic div, input logic [63:0] key, input logic [63:0] sent, input logic ok);
        logic [1:0] r;
        begin
            do_reset(1'b1, 1'b0, div);
            `CHK(monitor_mode, 1'b1)
            `CHK(clock_halve, div)
            `CHK(flash_access_ok, 1'b0)
            axi_wr(mms_pkg::ADDR_CTRL, 32'h8, r);
            `CHK(r, mms_pkg::RESP_OK)
            axi_wr(mms_pkg::ADDR_KEYL, key[31:0], r);
            axi_wr(mms_pkg::ADDR_KEYH, key[63:32], r);
            host_inst.rx_q.delete();
            for (int i = 0; i < 8; i++) begin
                if (i == 7) `CHK(flash_access_ok, 1'b0)
                host_inst.send_byte(sent[8*i +: 8]);
                gap(14);
            end
            gap(12);
            `CHK(host_inst.rx_q[$], 9'h000)
            `CHK(flash_access_ok, ok)
        end
    endtask

    // Every opcode with its operands; a result is refused until the READ command is whole.
    task automatic t_commands();
        logic [7:0] ops [6] = '{mms_pkg::OP_READ, mms_pkg::OP_WRITE, mms_pkg::OP_INDEXED_READ_CMD,
                                mms_pkg::OP_INDEXED_WRITE_CMD, mms_pkg::OP_STACK_POINTER_READ_CMD, mms_pkg::OP_RUN};
        int nopd [6] = '{2, 3, 0, 1, 0, 0};
        logic [1:0] r;
        logic [31:0] d;
        begin
            run_pulses = 0;
            for (int k = 0; k < 6; k++) begin
                echo_byte(ops[k]);
                axi_rd(mms_pkg::ADDR_RXD, d, r);
                `CHK(d[7:0], ops[k])
                axi_rd(mms_pkg::ADDR_STAT, d, r);
                `CHK(d[16:9], ops[k])
                if (k == 0) begin
                    axi_wr(mms_pkg::ADDR_TXD, 32'h5A, r);
                    `CHK(r, mms_pkg::RESP_ERR)
                end
                for (int j = 0; j < nopd[k]; j++) echo_byte(8'h30 + 8'(j));
                if (k == 0) begin
                    host_inst.rx_q.delete();
                    axi_wr(mms_pkg::ADDR_TXD, 32'h5A, r);
                    `CHK(r, mms_pkg::RESP_OK)
                    gap(14);
                    `CHK(host_inst.rx_q[$], 9'h15A)
                end
            end
            `CHK(run_pulses, 1)
        end
    endtask

    // A host break: two high bits, then a ten-bit low break echoed.
    task automatic t_break();
        logic [1:0] r;
        logic [31:0] d;
        begin
            host_inst.rx_q.delete();
            host_inst.send_break();
            gap(16);
            `CHK(host_inst.rx_q.size(), 1)
            `CHK(host_inst.rx_q[0], 9'h000)
            axi_rd(mms_pkg::ADDR_STAT, d, r);
            `CHK(d[4], 1'b1)
        end
    endtask

    // The watchdog stays off while either pin carries high voltage.
    task automatic t_watchdog();
        begin
            `CHK(watchdog_enable, 1'b0)
            irq_hv_pin <= 1'b0;
            repeat (4) @(posedge aclk);
            `CHK(watchdog_enable, 1'b1)
            rst_hv_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            `CHK(watchdog_enable, 1'b0)
            rst_hv_pin <= 1'b0;
            watchdog_disable_cfg <= 1'b1;
            repeat (4) @(posedge aclk);
            `CHK(watchdog_enable, 1'b0)
            `CHK(monitor_mode, 1'b1)
        end
    endtask

    initial begin
        t_entry();
        t_secure(1'b1, {32'hFFFFFFFF, 32'hFFFFFFFE}, {64{1'b1}}, 1'b0);
        t_secure(1'b0, 64'h0807060504030201, 64'h0807060504030201, 1'b1);
        t_commands();
        t_break();
        t_watchdog();
        close_out();
    end
endmodule
